// File: rtl/pmd_map.vh
/*
 * register map, bit positions and reset values of the peripheral module disable block.
 * assumes: included by bare name from the design files under rtl/.
 */
`ifndef PMD_MAP_VH
`define PMD_MAP_VH

// ----------------------------------------------------------------------------
// register byte offsets on the apb bus
// ----------------------------------------------------------------------------
`define PMD_OFS_CTRL0      8'h00
`define PMD_OFS_CTRL1      8'h04
`define PMD_OFS_STATUS     8'h08
`define PMD_ADDR_W         8

// ----------------------------------------------------------------------------
// first control register fields
// ----------------------------------------------------------------------------
`define PMD_BIT_SYSCLK     7
`define PMD_BIT_VREF       6
`define PMD_BIT_CHECKSUM   4
`define PMD_BIT_SCANNER    3
`define PMD_BIT_NVM        2
`define PMD_BIT_CLKREF     1
`define PMD_BIT_PINCHG     0
`define PMD_CTRL0_MASK     8'hdf
`define PMD_CTRL1_MASK     8'hff
`define PMD_CTRL_RESET     8'h00

// ----------------------------------------------------------------------------
// second control register fields and module count
// ----------------------------------------------------------------------------
`define PMD_BIT_NUMOSC     7
`define PMD_NUM_MODS       16
`define PMD_CTRL1_LSB      8

// ----------------------------------------------------------------------------
// re-enable settle window: one instruction cycle of four system clocks
// ----------------------------------------------------------------------------
`define PMD_SETTLE_CYC     3'h4
`define PMD_ZERO32         32'h00000000

`endif

// File: rtl/pmd_settle.v
/*
 * one settle counter per module: after a disable bit is cleared, the module is
 * reported not-ready for a fixed number of clocks.
 * assumes: sys_clk domain, synchronous active high reset.
 */
`timescale 1ns/1ps
`include "pmd_map.vh"

module pmd_settle (
    sys_clk,
    sys_rst,
    mod_off,
    mod_ready
);
    input  wire       sys_clk;
    input  wire       sys_rst;
    input  wire       mod_off;
    output wire       mod_ready;

    reg  [2:0] cnt_reg;
    reg  [2:0] cnt_next;

    // ------------------------------------------------------------------------
    // counter restarts while disabled, runs down after re-enable
    // ------------------------------------------------------------------------
    always @* begin
        cnt_next = cnt_reg;
        if (mod_off) begin
            cnt_next = `PMD_SETTLE_CYC;
        end else if (cnt_reg != 3'h0) begin
            cnt_next = cnt_reg - 3'h1;
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt_reg <= 3'h0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign mod_ready = (cnt_reg == 3'h0) && !mod_off; // within one instruction
endmodule

// File: rtl/pmd_apb.v
/*
 * apb slave front end: decodes accesses to the disable block registers.
 * assumes: apb3 master on sys_clk; zero wait states.
 */
`timescale 1ns/1ps
`include "pmd_map.vh"

module pmd_apb (
    psel,
    penable,
    pwrite,
    paddr,
    wr_ctrl0,
    wr_ctrl1,
    rd_hit
);
    input  wire                      psel;
    input  wire                      penable;
    input  wire                      pwrite;
    input  wire [`PMD_ADDR_W-1:0]    paddr;
    output wire                      wr_ctrl0;
    output wire                      wr_ctrl1;
    output wire                      rd_hit;

    wire access;

    // ------------------------------------------------------------------------
    // write strobes fire only in the access phase
    // ------------------------------------------------------------------------
    assign access   = psel && penable;
    assign wr_ctrl0 = access && pwrite && (paddr == `PMD_OFS_CTRL0);
    assign wr_ctrl1 = access && pwrite && (paddr == `PMD_OFS_CTRL1);
    assign rd_hit   = (paddr == `PMD_OFS_CTRL0) || (paddr == `PMD_OFS_CTRL1) || (paddr == `PMD_OFS_STATUS);
endmodule

// File: rtl/pmd_top.v
/*
 * peripheral module disable: two software control registers whose bits gate
 * clocks, hold resets, blank register access and release pins of peripherals.
 * assumes: apb3 master on sys_clk; peripherals honour the gate outputs.
 */
// The placing of the registers and the APB interface to the registers are this design's own decisions.
// Behaviour
// - all disable bits clear after any reset; modules enabled by default
// - a set bit blocks clock and control inputs of its module
// - a set bit holds its module in reset
// - disabled module: register writes ignored, reads return zero
// - disabled module outputs off; pin passes to next by priority
// - cleared bit: module restarts from reset with power-on values
// - re-enabled module active within one instruction cycle
// - disabling a module disables its input selection registers
// - control 0 bit 7 stops system clock to peripherals
// - control 0 bits 6,4,3,1,0 disable vref, checksum, scanner, clkref, pin change
// - control 0 bit 5 unimplemented, reads zero
// - nonvolatile off: memory access blocked, ctrl writes rejected, pointer reads zero
// - control 1 bit 7 numeric oscillator, bits 6..0 timers 6..0
// - implemented bits read/write, one disables, reset to zero
`timescale 1ns/1ps
`include "pmd_map.vh"

module pmd_top (
    sys_clk,
    sys_rst,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    periph_sysclk_off,
    mod_clk_gate,
    mod_rst_hold,
    mod_sfr_block,
    mod_pin_release,
    mod_insel_off,
    mod_ready,
    nonvolatile_off,
    nvm_ctrl_wr_block,
    nvm_ptr_rd_zero
);
    input  wire                       sys_clk;
    input  wire                       sys_rst;
    input  wire                       psel;
    input  wire                       penable;
    input  wire                       pwrite;
    input  wire [`PMD_ADDR_W-1:0]     paddr;
    input  wire [31:0]                pwdata;
    output reg  [31:0]                prdata;
    output wire                       pready;
    output wire                       pslverr;
    output reg                        periph_sysclk_off;
    output reg  [`PMD_NUM_MODS-1:0]   mod_clk_gate;
    output reg  [`PMD_NUM_MODS-1:0]   mod_rst_hold;
    output reg  [`PMD_NUM_MODS-1:0]   mod_sfr_block;
    output reg  [`PMD_NUM_MODS-1:0]   mod_pin_release;
    output reg  [`PMD_NUM_MODS-1:0]   mod_insel_off;
    output reg  [`PMD_NUM_MODS-1:0]   mod_ready;
    output reg                        nonvolatile_off;
    output reg                        nvm_ctrl_wr_block;
    output reg                        nvm_ptr_rd_zero;

    reg  [7:0]                 ctrl0_reg;
    reg  [7:0]                 ctrl1_reg;
    reg  [7:0]                 ctrl0_next;
    reg  [7:0]                 ctrl1_next;
    reg  [31:0]                prdata_next;
    wire                       wr_ctrl0;
    wire                       wr_ctrl1;
    wire                       rd_hit;
    wire [`PMD_NUM_MODS-1:0]   off_vec;
    wire [`PMD_NUM_MODS-1:0]   ready_vec;

    // ------------------------------------------------------------------------
    // bus decode and fixed-latency answer
    // ------------------------------------------------------------------------
    pmd_apb u_apb (
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .wr_ctrl0 (wr_ctrl0),
        .wr_ctrl1 (wr_ctrl1),
        .rd_hit   (rd_hit)
    );

    // zero wait states; unmapped offsets read zero and writes are dropped
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    // ------------------------------------------------------------------------
    // control registers: masked writes keep the unimplemented bit at zero
    // ------------------------------------------------------------------------
    always @* begin
        ctrl0_next = ctrl0_reg;
        ctrl1_next = ctrl1_reg;
        if (wr_ctrl0) begin
            ctrl0_next = pwdata[7:0] & `PMD_CTRL0_MASK;
        end
        if (wr_ctrl1) begin
            ctrl1_next = pwdata[7:0] & `PMD_CTRL1_MASK;
        end
    end

    always @(posedge sys_clk) begin
        if (sys_rst) begin
            ctrl0_reg <= `PMD_CTRL_RESET;
            ctrl1_reg <= `PMD_CTRL_RESET;
        end else begin
            ctrl0_reg <= ctrl0_next;
            ctrl1_reg <= ctrl1_next;
        end
    end

    // one disable vector: control 0 in the low byte, control 1 above it
    assign off_vec = {ctrl1_reg, ctrl0_reg};

    // ------------------------------------------------------------------------
    // per-module settle counters after re-enable
    // ------------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PMD_NUM_MODS; gi = gi + 1) begin : g_settle
            pmd_settle u_settle (
                .sys_clk   (sys_clk),
                .sys_rst   (sys_rst),
                .mod_off   (off_vec[gi]),
                .mod_ready (ready_vec[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------------
    // read mux: status shows which modules have settled
    // ------------------------------------------------------------------------
    always @* begin
        prdata_next = `PMD_ZERO32;
        if (psel && !penable && !pwrite && rd_hit) begin
            case (paddr)
                `PMD_OFS_CTRL0:  prdata_next = {24'h000000, ctrl0_reg};
                `PMD_OFS_CTRL1:  prdata_next = {24'h000000, ctrl1_reg};
                `PMD_OFS_STATUS: prdata_next = {16'h0000, ready_vec};
                default:         prdata_next = `PMD_ZERO32;
            endcase
        end else if (psel && penable) begin
            prdata_next = prdata; // hold through the access phase
        end
    end

    // ------------------------------------------------------------------------
    // gate outputs, all registered so they change one edge after the write;
    // the sysclk bit is a network gate, not a module, yet it still drives
    // the per-module reset hold of bit 7 of control 0 like any module bit
    // ------------------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata            <= `PMD_ZERO32;
            periph_sysclk_off <= 1'b0;
            mod_clk_gate      <= {`PMD_NUM_MODS{1'b0}};
            mod_rst_hold      <= {`PMD_NUM_MODS{1'b0}};
            mod_sfr_block     <= {`PMD_NUM_MODS{1'b0}};
            mod_pin_release   <= {`PMD_NUM_MODS{1'b0}};
            mod_insel_off     <= {`PMD_NUM_MODS{1'b0}};
            mod_ready         <= {`PMD_NUM_MODS{1'b0}};
            nonvolatile_off   <= 1'b0;
            nvm_ctrl_wr_block <= 1'b0;
            nvm_ptr_rd_zero   <= 1'b0;
        end else begin
            prdata            <= prdata_next;
            periph_sysclk_off <= ctrl0_reg[`PMD_BIT_SYSCLK];
            mod_clk_gate      <= off_vec;
            mod_rst_hold      <= off_vec;
            mod_sfr_block     <= off_vec;
            mod_pin_release   <= off_vec;
            mod_insel_off     <= off_vec;
            mod_ready         <= ready_vec;
            nonvolatile_off   <= ctrl0_reg[`PMD_BIT_NVM];
            nvm_ctrl_wr_block <= ctrl0_reg[`PMD_BIT_NVM];
            nvm_ptr_rd_zero   <= ctrl0_reg[`PMD_BIT_NVM];
        end
    end
endmodule

// File: test/pmd_chk_properties.sv
/*
 * checker: gate vectors of the module disable block against apb writes.
 * assumes: bound to pmd_top, a single sys_clk domain.
 */
`timescale 1ns/1ps
`include "pmd_map.vh"
module pmd_chk (
    input wire logic        sys_clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        periph_sysclk_off,
    input wire logic [15:0] mod_clk_gate,
    input wire logic [15:0] mod_rst_hold,
    input wire logic [15:0] mod_sfr_block,
    input wire logic [15:0] mod_pin_release,
    input wire logic [15:0] mod_insel_off,
    input wire logic [15:0] mod_ready,
    input wire logic        nonvolatile_off
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------------
    // write decode and gate follow-up
    // ------------------------------------------------------------------
    // decode here so a wrong offset in the design shows up
    wire wr0 = psel && penable && pwrite && paddr == `PMD_OFS_CTRL0;
    wire wr1 = psel && penable && pwrite && paddr == `PMD_OFS_CTRL1;
    property p_ctrl0_gate; wr0 |-> ##2 mod_clk_gate[7:0] == ($past(pwdata[7:0], 2) & 8'hdf); endproperty
    a_ctrl0_gate: assert property (p_ctrl0_gate) else $error("ctrl0 gate mismatch");
    property p_ctrl1_gate; wr1 |-> ##2 mod_clk_gate[15:8] == $past(pwdata[7:0], 2); endproperty
    a_ctrl1_gate: assert property (p_ctrl1_gate) else $error("ctrl1 gate mismatch");
    property p_rst_hold; mod_rst_hold == mod_clk_gate; endproperty
    a_rst_hold: assert property (p_rst_hold) else $error("reset hold mismatch");
    property p_sfr_block; mod_sfr_block == mod_clk_gate; endproperty
    a_sfr_block: assert property (p_sfr_block) else $error("register block mismatch");
    property p_pin_release; mod_pin_release == mod_clk_gate; endproperty
    a_pin_release: assert property (p_pin_release) else $error("pin release mismatch");
    property p_insel; mod_insel_off == mod_clk_gate; endproperty
    a_insel: assert property (p_insel) else $error("input select mismatch");
    property p_sysclk; periph_sysclk_off == mod_clk_gate[7]; endproperty
    a_sysclk: assert property (p_sysclk) else $error("clock network mismatch");
    property p_nvm; nonvolatile_off == mod_clk_gate[2]; endproperty
    a_nvm: assert property (p_nvm) else $error("memory off mismatch");
    property p_ready_off; (mod_ready & mod_clk_gate) == 16'h0000; endproperty
    a_ready_off: assert property (p_ready_off) else $error("ready while disabled");
    property p_reenable; $fell(mod_clk_gate[8]) |-> ##[0:6] mod_ready[8]; endproperty
    a_reenable: assert property (p_reenable) else $error("re-enable too slow");
    c_wr0: cover property (wr0);
    c_wr1: cover property (wr1);
    c_ready: cover property ($rose(mod_ready[8]));
endmodule

// File: test/pmd_periph_model.sv
/*
 * far-side model: one peripheral whose counter runs on the gated clock.
 * assumes: gate, hold and block levels come from pmd_top on sys_clk.
 */
`timescale 1ns/1ps
module pmd_periph_model (
    input  wire logic       sys_clk,
    input  wire logic       clk_gate,
    input  wire logic       rst_hold,
    input  wire logic       sfr_block,
    output logic      [7:0] sfr_rd
);
    logic [7:0] cnt_reg;
    // counts only on an ungated clock; a hold restores the power-on value
    always @(posedge sys_clk) begin
        if (rst_hold)
            cnt_reg <= 8'h00;
        else if (!clk_gate)
            cnt_reg <= cnt_reg + 8'h01;
    end
    // blocked registers read as zero
    assign sfr_rd = sfr_block ? 8'h00 : cnt_reg;
endmodule

// File: test/tb_top.sv
/*
 * testbench of pmd_top: apb master tasks and one task per scenario.
 * assumes: pmd_map.vh on the include path, zero-wait slave.
 */
`timescale 1ns/1ps
`include "pmd_map.vh"
module tb_top;
    logic        sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, t0_rd, b;
    logic [31:0] pwdata, prdata, rd;
    logic        periph_sysclk_off, nonvolatile_off, nvm_ctrl_wr_block, nvm_ptr_rd_zero;
    logic [15:0] mod_clk_gate, mod_rst_hold, mod_sfr_block, mod_pin_release, mod_insel_off, mod_ready;
    int          errors, check_count, i, n;
    pmd_top dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_sysclk_off(periph_sysclk_off), .mod_clk_gate(mod_clk_gate), .mod_rst_hold(mod_rst_hold),
        .mod_sfr_block(mod_sfr_block), .mod_pin_release(mod_pin_release), .mod_insel_off(mod_insel_off),
        .mod_ready(mod_ready), .nonvolatile_off(nonvolatile_off), .nvm_ctrl_wr_block(nvm_ctrl_wr_block),
        .nvm_ptr_rd_zero(nvm_ptr_rd_zero));
    pmd_periph_model u_t0 (.sys_clk(sys_clk), .clk_gate(mod_clk_gate[8]), .rst_hold(mod_rst_hold[8]),
        .sfr_block(mod_sfr_block[8]), .sfr_rd(t0_rd));
    // ------------------------------------------------------------------
    // clock, watchdog and shared tasks
    // ------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    // a hang costs a mismatch and ends the run
    initial begin
        #400000;
        errors++;
        end_sim;
    end
    task end_sim;
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held until pready is sampled high, read data taken there
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // no cycle limit here: only the watchdog ends a wait
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_regs;
        apb(1'b1, `PMD_OFS_CTRL0, 32'h000000ff);
        apb(1'b1, `PMD_OFS_CTRL1, 32'h000000a5);
        apb(1'b1, 8'h0c, 32'h000000ff);
        apb(1'b0, 8'h0c, 32'h0);
        chk(rd, 32'h0);
        chk({pready, pslverr}, 32'h2);
        apb(1'b0, `PMD_OFS_CTRL0, 32'h0);
        chk(rd, 32'h000000df);
        apb(1'b0, `PMD_OFS_CTRL1, 32'h0);
        chk(rd, 32'h000000a5);
        chk({mod_clk_gate, mod_rst_hold}, {2{16'ha5df}});
        chk({mod_sfr_block, mod_pin_release}, {2{16'ha5df}});
        chk(mod_insel_off, 16'ha5df);
        chk({periph_sysclk_off, nonvolatile_off, nvm_ctrl_wr_block, nvm_ptr_rd_zero}, 4'hf);
        apb(1'b0, `PMD_OFS_STATUS, 32'h0);
        chk(rd, 32'h00005a20);
    endtask
    // one disable bit at a time in both registers
    task t_bits;
        for (i = 0; i < 8; i++) begin
            b = 8'h01 << i;
            apb(1'b1, `PMD_OFS_CTRL0, {24'h0, b});
            apb(1'b1, `PMD_OFS_CTRL1, {24'h0, 8'h80 >> i});
            repeat (2) @(posedge sys_clk);
            chk(mod_clk_gate, {8'h80 >> i, b & 8'hdf});
        end
    endtask
    task t_reenable;
        apb(1'b1, `PMD_OFS_CTRL1, 32'h00000001);
        repeat (6) @(posedge sys_clk);
        chk(t0_rd, 8'h00);
        apb(1'b1, `PMD_OFS_CTRL1, 32'h0);
        n = 0;
        while (mod_ready[8] !== 1'b1 && n < 8) begin
            @(posedge sys_clk);
            n++;
        end
        chk(n <= 6, 1'b1);
        repeat (4) @(posedge sys_clk);
        chk(t0_rd != 8'h00 && t0_rd < 8'h10, 1'b1);
    endtask
    task t_midreset;
        apb(1'b1, `PMD_OFS_CTRL0, 32'h00000004);
        repeat (2) @(posedge sys_clk);
        chk(nonvolatile_off, 1'b1);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk({mod_clk_gate, 15'h0, nonvolatile_off}, 32'h0);
        repeat (10) @(posedge sys_clk);
        apb(1'b0, `PMD_OFS_CTRL0, 32'h0);
        chk(rd, 32'h0);
    endtask
    initial begin
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        errors = 0;
        check_count = 0;
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        // ready is registered, so it shows only from the first edge after release
        repeat (2) @(posedge sys_clk);
        chk({mod_clk_gate, mod_ready}, 32'h0000ffff);
        t_regs;
        t_bits;
        t_reenable;
        t_midreset;
        end_sim;
    end
endmodule
bind pmd_top pmd_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .periph_sysclk_off(periph_sysclk_off),
    .mod_clk_gate(mod_clk_gate), .mod_rst_hold(mod_rst_hold), .mod_sfr_block(mod_sfr_block),
    .mod_pin_release(mod_pin_release), .mod_insel_off(mod_insel_off), .mod_ready(mod_ready),
    .nonvolatile_off(nonvolatile_off));
